// ### design/led_sink_ctrl.sv
`default_nettype none
module led_sink_ctrl
   import led_sink_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // serial link from the display controller
   input  wire logic              shift_en,
   input  wire logic              serial_in,
   output logic                   serial_out,
   // multiplexed strobe and enable pins
   input  wire logic              latch_mode_strobe,
   input  wire logic              enable_switch_n,
   // outputs
   output logic [CHAN_W-1:0]      sink_channels,
   output logic [CHAN_W-1:0]      gain_code,
   output logic [1:0]             phase,
   // captured words, buffered
   output logic                   word_valid,
   output logic [CHAN_W-1:0]      word_data,
   input  wire logic              word_ready
);
   phase_e            phase_reg;
   phase_e            phase_next;
   logic [CHAN_W-1:0] shift_reg;
   logic [CHAN_W-1:0] out_latch_reg;
   logic [CHAN_W-1:0] config_reg;
   logic [1:0]        en_hist_reg;
   logic              strobe_d_reg;
   logic              pend_reg;
   stream_if          cap ();

   wire mode_switch_trigger;
   wire output_latch_strobe;
   wire config_latch_strobe;
   wire mode_select_level;
   wire strobe_rise;
   wire shift_go;

   // a one-clock high pulse on enable, counted in shift-clock periods
   assign mode_switch_trigger = shift_en && !enable_switch_n && en_hist_reg[0]
                                && !en_hist_reg[1];
   assign output_latch_strobe = (phase_reg == PH_NORMAL) && latch_mode_strobe;
   assign config_latch_strobe = (phase_reg == PH_ADJUST) && latch_mode_strobe
                                && !strobe_d_reg;
   assign mode_select_level   = latch_mode_strobe;
   assign strobe_rise         = config_latch_strobe;
   // back-pressure: shifting stalls while a word waits for room
   assign shift_go            = shift_en && !pend_reg;

   // phase machine
   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         PH_NORMAL,
         PH_ADJUST: if (mode_switch_trigger) phase_next = PH_SWITCH;
         PH_SWITCH: begin
            if (shift_en) begin
               phase_next = mode_select_level ? PH_ADJUST : PH_NORMAL;
            end
         end
         default:   phase_next = PH_NORMAL;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_reg <= PH_NORMAL;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // enable history sampled on shift edges
   always_ff @(posedge clk) begin
      if (rst) begin
         en_hist_reg  <= 2'b00;
         strobe_d_reg <= 1'b0;
      end else begin
         if (shift_en) en_hist_reg <= {en_hist_reg[0], enable_switch_n};
         strobe_d_reg <= latch_mode_strobe;
      end
   end

   // eight-bit serial chain
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_reg <= LATCH_RST;
      end else if (shift_go) begin
         shift_reg <= {shift_reg[CHAN_W-2:0], serial_in};
      end
   end

   // transparent while strobe high in normal mode; switching phase loads nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         out_latch_reg <= LATCH_RST;
      end else if (output_latch_strobe) begin
         out_latch_reg <= shift_reg;
      end
   end

   // configuration latch, loaded directly on the strobe edge; the same word is pushed into the buffer then, or held pending until it has room
   assign cap.valid = pend_reg;
   assign cap.data  = shift_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_reg   <= 1'b0;
         config_reg <= CONFIG_RST;
      end else begin
         if (strobe_rise) begin
            config_reg <= shift_reg;
         end
         if (strobe_rise && !cap.ready) pend_reg <= 1'b1;
         else if (cap.ready) pend_reg <= 1'b0;
      end
   end

   byte_fifo #(.WIDTH(CHAN_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .in_valid (cap.valid || strobe_rise),
      .in_data  (cap.data),
      .in_ready (cap.ready),
      .out_valid(word_valid),
      .out_data (word_data),
      .out_ready(word_ready)
   );

   // output stage
   assign serial_out    = shift_reg[CHAN_W-1];
   assign sink_channels = enable_switch_n ? '0 : out_latch_reg;
   assign gain_code     = config_reg;
   assign phase         = phase_reg;
endmodule
`default_nettype wire

// ### design/led_sink_pkg.sv
`default_nettype none
package led_sink_pkg;
   localparam int          CHAN_W     = 8;
   localparam int          FIFO_DEPTH = 32;
   localparam logic [7:0]  LATCH_RST  = 8'h00;
   localparam logic [7:0]  CONFIG_RST = 8'hFF;
   typedef enum logic [1:0] {
      PH_NORMAL = 2'b00,
      PH_SWITCH = 2'b01,
      PH_ADJUST = 2'b10
   } phase_e;
endpackage
`default_nettype wire

// ### design/stream_if.sv
`default_nettype none
// byte stream between the shift path and the buffer
interface stream_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### design/byte_fifo.sv
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // drain side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   wire              push;
   wire              pop;

   // honest full and empty from the fill count
   assign in_ready  = (cnt_reg < (AW+1)'(DEPTH)); // full only at the documented depth
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage has no reset, pointers do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop)  rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ### tb/led_sink_ctrl_properties.sv
`default_nettype none
module led_sink_ctrl_properties
   import led_sink_pkg::*;
(
   // watched pins
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       shift_en,
   input wire logic       latch_mode_strobe,
   input wire logic       enable_switch_n,
   input wire logic [7:0] sink_channels,
   input wire logic [7:0] gain_code,
   input wire logic [1:0] phase,
   input wire logic       word_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // blanking and latch holding
   property p_blank; enable_switch_n |-> sink_channels == 8'h00; endproperty
   a_blank: assert property (p_blank) else $error("lit");
   property p_hold; !enable_switch_n && $past(!enable_switch_n) && !($past(latch_mode_strobe)
      && $past(phase) == PH_NORMAL) |-> $stable(sink_channels); endproperty
   a_hold: assert property (p_hold) else $error("latch moved");
   // gain moves only on an adjust strobe, and queues a word
   property p_gain; $changed(gain_code) |-> $past(phase) == PH_ADJUST; endproperty
   a_gain: assert property (p_gain) else $error("gain moved");
   property p_word; $changed(gain_code) |-> ##[0:4] word_valid; endproperty
   a_word: assert property (p_word) else $error("no word");
   // mode choice and trigger
   property p_sel; $past(phase) == PH_SWITCH && $past(shift_en) |->
      phase == ($past(latch_mode_strobe) ? PH_ADJUST : PH_NORMAL); endproperty
   a_sel: assert property (p_sel) else $error("bad mode");
   property p_enter; phase == PH_SWITCH && $past(phase) != PH_SWITCH |-> $past(enable_switch_n)
      || $past(enable_switch_n, 2) || $past(enable_switch_n, 3); endproperty
   a_enter: assert property (p_enter) else $error("bad entry");
   property p_move; $changed(phase) |-> $past(shift_en) || $past(shift_en, 2); endproperty
   a_move: assert property (p_move) else $error("phase jump");
   property p_legal; phase != 2'b11; endproperty
   a_legal: assert property (p_legal) else $error("bad phase");
endmodule
bind led_sink_ctrl led_sink_ctrl_properties i_props (.clk, .rst, .shift_en, .latch_mode_strobe,
   .enable_switch_n, .sink_channels, .gain_code, .phase, .word_valid);
`default_nettype wire

// ### tb/led_ctrl_model.sv
`default_nettype none
module led_ctrl_model (
   // controller pins
   input  wire logic clk,
   output logic      shift_en = 1'b0,
   output logic      serial_in = 1'b0,
   output logic      latch_mode_strobe = 1'b0,
   output logic      enable_switch_n = 1'b0,
   output logic      word_ready = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // one shift period; data flips once its hold is over
   task tick(input logic d);
      @(negedge clk);
      serial_in = d;
      shift_en = 1'b1;
      @(negedge clk);
      shift_en = 1'b0;
      serial_in = ~d;
   endtask
   task send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) tick(b[i]);
   endtask
   task strobe;
      @(negedge clk);
      latch_mode_strobe = 1'b1;
      @(negedge clk);
      latch_mode_strobe = 1'b0;
   endtask
   // trigger over one sampling edge, then hold the mode level
   // the level rises only after the trigger edge, else normal mode takes it as a latch strobe
   task switch_to(input logic adj);
      tick(1'b0);
      enable_switch_n = 1'b1;
      tick(1'b0);
      enable_switch_n = 1'b0;
      tick(1'b0);
      latch_mode_strobe = adj;
      tick(1'b0);
      latch_mode_strobe = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_led_sink_ctrl.sv
`default_nettype none
module tb_led_sink_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import led_sink_pkg::*;
   logic            clk = 1'b0;
   logic            rst = 1'b1;
   wire logic       shift_en, serial_in, serial_out, latch_mode_strobe, enable_switch_n;
   wire logic       word_valid, word_ready;
   wire logic [7:0] sink_channels, gain_code, word_data;
   wire logic [1:0] phase;
   int              bad_count = 0;
   int              comparisons = 0;
   int              n;
   led_ctrl_model i_host (.clk, .shift_en, .serial_in, .latch_mode_strobe, .enable_switch_n,
      .word_ready);
   led_sink_ctrl i_dut (.clk, .rst, .shift_en, .serial_in, .serial_out, .latch_mode_strobe,
      .enable_switch_n, .sink_channels, .gain_code, .phase, .word_valid, .word_data, .word_ready);
   initial forever #2 clk = ~clk;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("compares %0d bad %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task t_normal;
      chk(gain_code, CONFIG_RST);
      chk({6'h00, phase}, 8'h00);
      i_host.send(8'hA5);
      i_host.strobe();
      chk(sink_channels, 8'hA5);
      chk({7'h00, serial_out}, 8'h01);
      i_host.send(8'h3C);
      chk(sink_channels, 8'hA5);
      $display("normal done");
   endtask
   // fill the buffer with gain words, then drain it
   task t_adjust;
      i_host.switch_to(1'b1);
      chk({6'h00, phase}, 8'h02);
      chk(gain_code, CONFIG_RST);
      for (int i = 1; i <= FIFO_DEPTH; i++) begin
         i_host.send(8'(i));
         i_host.strobe();
      end
      chk(gain_code, 8'h20);
      chk(sink_channels, 8'hA5);
      i_host.word_ready = 1'b1;
      n = 0;
      repeat (40) begin
         if (word_valid === 1'b1) begin
            n++;
            chk(word_data, 8'(n));
         end
         @(negedge clk);
      end
      chk(8'(n), 8'h20);
      i_host.switch_to(1'b0);
      chk({6'h00, phase}, 8'h00);
      i_host.enable_switch_n = 1'b1;
      #1 chk(sink_channels, 8'h00);
      $display("adjust done");
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_normal;
      t_adjust;
      report_and_stop;
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      report_and_stop;
   end
endmodule
`default_nettype wire
